// File: dual_phase_correct_pwm_timer_bench.sv
// Self-checking bench for the phase-correct PWM timer
`timescale 1ns/1ps
module dual_phase_correct_pwm_timer_bench;
    `define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
        $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end

    logic       i_sys_clk;
    logic       i_reset_n;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic       clr;
    wire  [7:0] o_rdata;
    wire        o_pwm_out_a;
    wire        o_pwm_out_a_oe;
    wire        o_pwm_out_b;
    wire        o_pwm_out_b_oe;
    wire        o_irq;
    int         high_a;
    int         high_b;
    int         width_a;
    int         edges_a;
    int         errors = 0;
    int         checks_done = 0;
    logic [7:0] v;
    logic [9:0] w;

    typedef struct {
        logic [1:0] res;
        logic [1:0] ma;
        logic [1:0] mb;
        int         ca;
        int         cb;
        int         peak;
    } row_t;
    row_t rows [5] = '{'{2'h1, 2'h0, 2'h3, 30, 255, 255}, '{2'h1, 2'h2, 2'h3, 100, 100, 255},
                       '{2'h2, 2'h3, 2'h2, 0, 511, 511}, '{2'h3, 2'h1, 2'h2, 300, 0, 1023},
                       '{2'h0, 2'h2, 2'h3, 1, 1022, 1023}};

    pwm_timer pwm_timer_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_pwm_out_a(o_pwm_out_a), .o_pwm_out_a_oe(o_pwm_out_a_oe),
        .o_pwm_out_b(o_pwm_out_b), .o_pwm_out_b_oe(o_pwm_out_b_oe), .o_irq(o_irq));

    pwm_load_model pwm_load_model_i (.i_sys_clk(i_sys_clk), .i_clear(clr),
        .i_pin_a(o_pwm_out_a), .i_oe_a(o_pwm_out_a_oe), .i_pin_b(o_pwm_out_b),
        .i_oe_b(o_pwm_out_b_oe), .o_high_a(high_a), .o_high_b(high_b),
        .o_width_a(width_a), .o_edges_a(edges_a));

    function automatic int exp_high(input logic [1:0] m, input int c, input int p);
        if (m[1] === 1'b0)
            return 0;
        if (m[0] === 1'b0)
            return 2 * c;
        return 2 * p - 2 * c;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Main flow only, so the shared byte latch is never interleaved
    task automatic wr16(input logic [3:0] lo, input logic [9:0] d);
        wr(lo + 4'h1, {6'h00, d[9:8]});
        wr(lo, d[7:0]);
    endtask

    task automatic rd16(input logic [3:0] lo, output logic [9:0] d);
        logic [7:0] l;
        logic [7:0] h;
        rd(lo, l);
        rd(lo + 4'h1, h);
        d = {h[1:0], l};
    endtask

    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        while (o_pwm_out_a !== lvl && n < 5000)
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        `CHECK(o_pwm_out_a, lvl)
    endtask

    task automatic measure(input int n);
        @(posedge i_sys_clk);
        clr <= 1'b1;
        @(posedge i_sys_clk);
        clr <= 1'b0;
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    initial
    begin
        #400us;
        errors++;
        print_verdict();
    end

    initial
    begin
        i_reset_n = 1'b0;
        i_addr    = 4'h0;
        i_wdata   = 8'h00;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        clr       = 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_DIV1});
        foreach (rows[k])
        begin
            wr(pwm_timer_pkg::OFF_CONTROL, {rows[k].ma, rows[k].mb, 2'h0, rows[k].res});
            wr16(pwm_timer_pkg::OFF_CMP_A_LO, rows[k].ca[9:0]);
            wr16(pwm_timer_pkg::OFF_CMP_B_LO, rows[k].cb[9:0]);
            rd16(pwm_timer_pkg::OFF_CMP_B_LO, w);
            `CHECK(w, rows[k].cb[9:0])
            repeat (4 * rows[k].peak) @(posedge i_sys_clk);
            measure(2 * rows[k].peak);
            `CHECK(high_a, exp_high(rows[k].ma, rows[k].ca, rows[k].peak))
            `CHECK(high_b, exp_high(rows[k].mb, rows[k].cb, rows[k].peak))
            `CHECK(o_pwm_out_a_oe, rows[k].ma[1])
            `CHECK(o_pwm_out_b_oe, rows[k].mb[1])
        end
        // Second reset in mid-run
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        `CHECK({o_pwm_out_a, o_pwm_out_a_oe, o_pwm_out_b, o_pwm_out_b_oe, o_irq}, 5'h00)
        @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        for (int a = 0; a < 10; a++)
        begin
            rd(a[3:0], v);
            `CHECK(v, 8'h00)
        end
        wr(4'hf, 8'h5a);
        rd(4'hf, v);
        `CHECK(v, 8'h00)
        wr(pwm_timer_pkg::OFF_CONTROL, 8'ha1);
        wr16(pwm_timer_pkg::OFF_CMP_A_LO, 10'h064);
        wr16(pwm_timer_pkg::OFF_CMP_B_LO, 10'h032);
        wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_DIV1});
        repeat (1100) @(posedge i_sys_clk);
        // Write lands mid-pulse; the running pulse must keep its old length
        wait_pin(1'b0);
        wait_pin(1'b1);
        wr16(pwm_timer_pkg::OFF_CMP_A_LO, 10'h014);
        rd16(pwm_timer_pkg::OFF_CMP_A_LO, w);
        `CHECK(w, 10'h014)
        wait_pin(1'b0);
        repeat (3) @(posedge i_sys_clk);
        `CHECK(width_a, 200)
        wait_pin(1'b1);
        wait_pin(1'b0);
        repeat (3) @(posedge i_sys_clk);
        `CHECK(width_a, 40)
        rd(pwm_timer_pkg::OFF_IRQ_STATUS, v);
        repeat (520) @(posedge i_sys_clk);
        `CHECK(o_irq, 1'b0)
        rd(pwm_timer_pkg::OFF_IRQ_STATUS, v);
        `CHECK(v, 8'h07)
        wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_STOP});
        wr16(pwm_timer_pkg::OFF_COUNT_LO, 10'h014);
        rd(pwm_timer_pkg::OFF_IRQ_STATUS, v);
        repeat (20) @(posedge i_sys_clk);
        rd(pwm_timer_pkg::OFF_IRQ_STATUS, v);
        `CHECK(v, 8'h00)
        wr(pwm_timer_pkg::OFF_IRQ_MASK, 8'h01);
        wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_DIV1});
        for (int n = 0; n < 1200 && o_irq !== 1'b1; n++)
        begin
            @(posedge i_sys_clk);
            #1;
        end
        `CHECK(o_irq, 1'b1)
        rd16(pwm_timer_pkg::OFF_COUNT_LO, w);
        `CHECK(w < 10'h00c, 1'b1)
        rd(pwm_timer_pkg::OFF_IRQ_STATUS, v);
        `CHECK(v[0], 1'b1)
        @(posedge i_sys_clk);
        #1;
        `CHECK(o_irq, 1'b0)
        // Divided clock with compare at the peak still gives a pulse
        wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_DIV8});
        wr16(pwm_timer_pkg::OFF_CMP_A_LO, 10'h0ff);
        repeat (4200) @(posedge i_sys_clk);
        measure(12300);
        `CHECK(edges_a > 0, 1'b1)
        // Slow dividers: about ten ticks in ten divider spans, either direction
        for (int s = 3; s < 6; s++)
        begin
            wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_STOP});
            wr16(pwm_timer_pkg::OFF_COUNT_LO, 10'h080);
            wr(pwm_timer_pkg::OFF_CLOCK_SEL, s[7:0]);
            repeat (10 << (2 * s)) @(posedge i_sys_clk);
            wr(pwm_timer_pkg::OFF_CLOCK_SEL, {5'h00, pwm_timer_pkg::CS_STOP});
            rd16(pwm_timer_pkg::OFF_COUNT_LO, w);
            `CHECK(w >= 10'h075 && w <= 10'h08b, 1'b1)
        end
        print_verdict();
    end
endmodule

// File: pwm_compare_channel.sv
// One compare channel: double-buffered value, match and pin logic
`timescale 1ns/1ps
module pwm_compare_channel #(
    parameter int CMP_W = 10
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    // Counter state
    input  wire logic             i_tick,
    input  wire logic [CMP_W-1:0] i_count,
    input  wire logic             i_counting_up,
    input  wire logic             i_at_peak,
    input  wire logic             i_div1,
    // Software side
    input  wire logic             i_wr_en,
    input  wire logic [CMP_W-1:0] i_wr_value,
    input  wire logic [1:0]       i_mode,
    // Results
    output logic [CMP_W-1:0]      o_held_value,
    output logic                  o_match,
    output logic                  o_pin
);
    if (CMP_W != 10) $error("CMP_W must be 10");

    logic [CMP_W-1:0] hold_reg, hold_next;
    logic [CMP_W-1:0] active_reg, active_next;
    logic             pin_reg, pin_next;
    logic             peak_set_reg, peak_set_next;
    logic             match;

    always_comb
    begin
        hold_next     = i_wr_en ? i_wr_value : hold_reg;
        active_next   = active_reg;
        pin_next      = pin_reg;
        peak_set_next = peak_set_reg;
        match         = 1'b0;
        if (i_tick)
        begin
            match = (i_count == active_reg);
            if (match && i_mode[1])
            begin
                if (i_at_peak && i_count != '0)
                begin
                    // Peak match: up and down match coincide at the turn
                    if (!i_div1 && !peak_set_reg)
                    begin
                        pin_next      = ~i_mode[0];
                        peak_set_next = 1'b1;
                    end
                    else if (!i_div1)
                    begin
                        pin_next      = i_mode[0];
                        peak_set_next = 1'b0;
                    end
                    else
                        pin_next = ~i_mode[0];
                end
                // Zero is the turn point, so its match acts as up-count
                else if (i_counting_up || i_count == '0)
                    pin_next = i_mode[0];
                else
                    pin_next = ~i_mode[0];
            end
            if (i_at_peak)
                active_next = hold_reg;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hold_reg     <= '0;
            active_reg   <= '0;
            pin_reg      <= 1'b0;
            peak_set_reg <= 1'b0;
        end
        else
        begin
            hold_reg     <= hold_next;
            active_reg   <= active_next;
            pin_reg      <= pin_next;
            peak_set_reg <= peak_set_next;
        end
    end

    assign o_held_value = hold_reg;
    assign o_match      = match;
    assign o_pin        = pin_reg;

    property p_transfer;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_tick && i_at_peak) |=> (active_reg == $past(hold_reg));
    endproperty
    a_transfer: assert property (p_transfer) else $error("compare transfer missed");

    property p_noninv_up;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_tick && match && i_mode == 2'h2 && i_counting_up && !i_at_peak) |=> !pin_reg;
    endproperty
    a_noninv_up: assert property (p_noninv_up) else $error("non-inverted up match wrong");

    property p_inv_up;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_tick && match && i_mode == 2'h3 && i_counting_up && !i_at_peak) |=> pin_reg;
    endproperty
    a_inv_up: assert property (p_inv_up) else $error("inverted up match wrong");

    property p_no_write_drift;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!(i_tick && i_at_peak)) |=> $stable(active_reg);
    endproperty
    a_no_write_drift: assert property (p_no_write_drift) else $error("active changed off peak");

    property p_readback;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_wr_en |=> (o_held_value == $past(i_wr_value));
    endproperty
    a_readback: assert property (p_readback) else $error("readback not latest write");
endmodule

// File: pwm_load_model.sv
// Load on the two PWM pins that times high levels, and pulses on pin A only
`timescale 1ns/1ps
module pwm_load_model (
    // Clock and control
    input  wire logic i_sys_clk,
    input  wire logic i_clear,
    // Pin drive from the timer
    input  wire logic i_pin_a,
    input  wire logic i_oe_a,
    input  wire logic i_pin_b,
    input  wire logic i_oe_b,
    // Measurements
    output int        o_high_a = 0,
    output int        o_high_b = 0,
    output int        o_width_a = 0,
    output int        o_edges_a = 0
);
    logic line_a = 1'b0;
    logic line_b = 1'b0;
    int   run_a  = 0;

    always @(posedge i_sys_clk)
    begin
        // No pull on these wires: a released line flips its level every clock
        line_a <= i_oe_a ? i_pin_a : ~line_a;
        line_b <= i_oe_b ? i_pin_b : ~line_b;
        if (i_clear)
        begin
            o_high_a  <= 0;
            o_high_b  <= 0;
            o_edges_a <= 0;
        end
        else
        begin
            o_high_a <= o_high_a + ((i_oe_a && line_a) ? 1 : 0);
            o_high_b <= o_high_b + ((i_oe_b && line_b) ? 1 : 0);
            if (i_oe_a && (i_pin_a !== line_a))
                o_edges_a <= o_edges_a + 1;
        end
        if (i_oe_a && line_a)
            run_a <= run_a + 1;
        else if (run_a != 0)
        begin
            o_width_a <= run_a;
            run_a     <= 0;
        end
    end
endmodule

// File: pwm_timer.sv
// Dual phase-correct PWM timer with register port and interrupt
//
// How it works
// - Count zero to peak, back down, forever
// - Peak 255, 511 or 1023 by resolution
// - Compare counter to ten low compare bits
// - Mode 10: clear up, set down
// - Mode 11: clear down, set up
// - Modes 00 and 01 disconnect the pin
// - Compare writes held until peak transfer
// - Compare read returns most recent write
// - Zero or undivided peak compare gives fixed level
// - Peak compare undivided: no pulse
// - Peak compare divided: one-period pulse
// - Overflow flag set leaving zero
// - Flags request interrupt when enabled
// - Match flag set only on event
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pwm_timer #(
    parameter int CNT_W = 10
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // Pins and interrupt
    output logic            o_pwm_out_a,
    output logic            o_pwm_out_a_oe,
    output logic            o_pwm_out_b,
    output logic            o_pwm_out_b_oe,
    output logic            o_irq
);
    if (CNT_W != 10) $error("CNT_W must be 10");

    pwm_timer_pkg::reg_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Registers
    logic [7:0]       timer_control_a_reg, timer_control_a_next;
    logic [2:0]       clock_select_reg, clock_select_next;
    logic [7:0]       byte_latch_reg, byte_latch_next;
    logic [2:0]       irq_status_reg, irq_status_next;
    logic [2:0]       irq_mask_reg, irq_mask_next;
    logic [7:0]       rdata_reg, rdata_next;
    logic [CNT_W-1:0] counter_value_reg, counter_value_next;
    logic             counting_up_reg, counting_up_next;
    logic [pwm_timer_pkg::PRESCALE_W-1:0] presc_reg, presc_next;

    logic [CNT_W-1:0] peak;
    logic             tick;
    logic             at_peak;
    logic             wr_cmp_a;
    logic             wr_cmp_b;
    logic [CNT_W-1:0] held_a;
    logic [CNT_W-1:0] held_b;
    logic             match_a;
    logic             match_b;
    logic             pin_a;
    logic             pin_b;
    logic             overflow_evt;
    logic             wr_count;

    // Resolution select
    always_comb
    begin
        unique case (timer_control_a_reg[pwm_timer_pkg::CTL_RES_HI:pwm_timer_pkg::CTL_RES_LO])
            2'h1:    peak = pwm_timer_pkg::PEAK_8;
            2'h2:    peak = pwm_timer_pkg::PEAK_9;
            default: peak = pwm_timer_pkg::PEAK_10;
        endcase
    end

    // Prescaler: stopped clock select yields no ticks
    always_comb
    begin
        presc_next = presc_reg + 1'b1;
        unique case (clock_select_reg)
            pwm_timer_pkg::CS_DIV1:   tick = 1'b1;
            pwm_timer_pkg::CS_DIV8:   tick = (presc_reg[2:0] == 3'h7);
            pwm_timer_pkg::CS_DIV64:  tick = (presc_reg[5:0] == 6'h3f);
            pwm_timer_pkg::CS_DIV256: tick = (presc_reg[7:0] == 8'hff);
            pwm_timer_pkg::CS_DIV1K:  tick = (presc_reg == 10'h3ff);
            default:                  tick = 1'b0;
        endcase
        if (clock_select_reg == pwm_timer_pkg::CS_STOP)
            presc_next = '0;
    end

    assign at_peak = (counter_value_reg == peak);

    // Counter direction and value
    always_comb
    begin
        counter_value_next = counter_value_reg;
        counting_up_next   = counting_up_reg;
        overflow_evt       = 1'b0;
        wr_count           = req.wr && req.addr == pwm_timer_pkg::OFF_COUNT_LO;
        if (wr_count)
            counter_value_next = {byte_latch_reg[1:0], req.wdata};
        else if (tick)
        begin
            if (counter_value_reg >= peak)
            begin
                counting_up_next   = 1'b0;
                counter_value_next = peak - 1'b1;
            end
            else if (counter_value_reg == '0)
            begin
                counting_up_next   = 1'b1;
                counter_value_next = 10'h001;
                overflow_evt       = 1'b1;
            end
            else if (counting_up_reg)
                counter_value_next = counter_value_reg + 1'b1;
            else
                counter_value_next = counter_value_reg - 1'b1;
        end
    end

    assign wr_cmp_a = req.wr && req.addr == pwm_timer_pkg::OFF_CMP_A_LO;
    assign wr_cmp_b = req.wr && req.addr == pwm_timer_pkg::OFF_CMP_B_LO;

    pwm_compare_channel #(.CMP_W(CNT_W)) u_chan_a (
        .i_sys_clk     (i_sys_clk),
        .i_reset_n     (i_reset_n),
        .i_tick        (tick),
        .i_count       (counter_value_reg),
        .i_counting_up (counting_up_reg),
        .i_at_peak     (at_peak),
        .i_div1        (clock_select_reg == pwm_timer_pkg::CS_DIV1),
        .i_wr_en       (wr_cmp_a),
        .i_wr_value    ({byte_latch_reg[1:0], req.wdata}),
        .i_mode        (timer_control_a_reg[pwm_timer_pkg::CTL_MODE_A_HI:
                                            pwm_timer_pkg::CTL_MODE_A_LO]),
        .o_held_value  (held_a),
        .o_match       (match_a),
        .o_pin         (pin_a)
    );

    pwm_compare_channel #(.CMP_W(CNT_W)) u_chan_b (
        .i_sys_clk     (i_sys_clk),
        .i_reset_n     (i_reset_n),
        .i_tick        (tick),
        .i_count       (counter_value_reg),
        .i_counting_up (counting_up_reg),
        .i_at_peak     (at_peak),
        .i_div1        (clock_select_reg == pwm_timer_pkg::CS_DIV1),
        .i_wr_en       (wr_cmp_b),
        .i_wr_value    ({byte_latch_reg[1:0], req.wdata}),
        .i_mode        (timer_control_a_reg[pwm_timer_pkg::CTL_MODE_B_HI:
                                            pwm_timer_pkg::CTL_MODE_B_LO]),
        .o_held_value  (held_b),
        .o_match       (match_b),
        .o_pin         (pin_b)
    );

    // Register file, shared byte latch and sticky flags
    always_comb
    begin
        timer_control_a_next = timer_control_a_reg;
        clock_select_next    = clock_select_reg;
        byte_latch_next      = byte_latch_reg;
        irq_mask_next        = irq_mask_reg;
        irq_status_next      = irq_status_reg;
        rdata_next           = 8'h00;
        // Read clears first so a same-cycle event survives
        if (req.rd && req.addr == pwm_timer_pkg::OFF_IRQ_STATUS)
            irq_status_next = 3'h0;
        if (overflow_evt)
            irq_status_next[pwm_timer_pkg::ST_OVERFLOW] = 1'b1;
        if (match_a)
            irq_status_next[pwm_timer_pkg::ST_MATCH_A] = 1'b1;
        if (match_b)
            irq_status_next[pwm_timer_pkg::ST_MATCH_B] = 1'b1;
        if (req.wr)
        begin
            unique case (req.addr)
                pwm_timer_pkg::OFF_CONTROL:   timer_control_a_next = req.wdata;
                pwm_timer_pkg::OFF_CLOCK_SEL: clock_select_next = req.wdata[2:0];
                pwm_timer_pkg::OFF_COUNT_HI,
                pwm_timer_pkg::OFF_CMP_A_HI,
                pwm_timer_pkg::OFF_CMP_B_HI:  byte_latch_next = req.wdata;
                pwm_timer_pkg::OFF_IRQ_MASK:  irq_mask_next = req.wdata[2:0];
                default:                      byte_latch_next = byte_latch_reg;
            endcase
        end
        if (req.rd)
        begin
            unique case (req.addr)
                pwm_timer_pkg::OFF_CONTROL:    rdata_next = timer_control_a_reg;
                pwm_timer_pkg::OFF_CLOCK_SEL:  rdata_next = {5'h00, clock_select_reg};
                pwm_timer_pkg::OFF_COUNT_LO:
                begin
                    rdata_next      = counter_value_reg[7:0];
                    byte_latch_next = {6'h00, counter_value_reg[9:8]};
                end
                pwm_timer_pkg::OFF_CMP_A_LO:
                begin
                    rdata_next      = held_a[7:0];
                    byte_latch_next = {6'h00, held_a[9:8]};
                end
                pwm_timer_pkg::OFF_CMP_B_LO:
                begin
                    rdata_next      = held_b[7:0];
                    byte_latch_next = {6'h00, held_b[9:8]};
                end
                pwm_timer_pkg::OFF_COUNT_HI,
                pwm_timer_pkg::OFF_CMP_A_HI,
                pwm_timer_pkg::OFF_CMP_B_HI:   rdata_next = byte_latch_reg;
                pwm_timer_pkg::OFF_IRQ_STATUS: rdata_next = {5'h00, irq_status_reg};
                pwm_timer_pkg::OFF_IRQ_MASK:   rdata_next = {5'h00, irq_mask_reg};
                default:                       rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            timer_control_a_reg <= pwm_timer_pkg::CONTROL_RST;
            clock_select_reg    <= pwm_timer_pkg::CLK_SEL_RST;
            byte_latch_reg      <= 8'h00;
            irq_status_reg      <= pwm_timer_pkg::IRQ_RST;
            irq_mask_reg        <= pwm_timer_pkg::IRQ_RST;
            rdata_reg           <= 8'h00;
            counter_value_reg   <= pwm_timer_pkg::COUNT_RST;
            counting_up_reg     <= 1'b1;
            presc_reg           <= '0;
        end
        else
        begin
            timer_control_a_reg <= timer_control_a_next;
            clock_select_reg    <= clock_select_next;
            byte_latch_reg      <= byte_latch_next;
            irq_status_reg      <= irq_status_next;
            irq_mask_reg        <= irq_mask_next;
            rdata_reg           <= rdata_next;
            counter_value_reg   <= counter_value_next;
            counting_up_reg     <= counting_up_next;
            presc_reg           <= presc_next;
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_irq          = |(irq_status_reg & irq_mask_reg);
    assign o_pwm_out_a_oe = timer_control_a_reg[pwm_timer_pkg::CTL_MODE_A_HI];
    assign o_pwm_out_b_oe = timer_control_a_reg[pwm_timer_pkg::CTL_MODE_B_HI];
    assign o_pwm_out_a    = o_pwm_out_a_oe & pin_a;
    assign o_pwm_out_b    = o_pwm_out_b_oe & pin_b;

    property p_turn_at_peak;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (tick && at_peak && !wr_count) |=> (!counting_up_reg && counter_value_reg == $past(peak) - 1'b1);
    endproperty
    a_turn_at_peak: assert property (p_turn_at_peak) else $error("no turn at peak");

    property p_overflow_leave_zero;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (tick && counter_value_reg == '0 && !wr_count) |=> irq_status_reg[0];
    endproperty
    a_overflow_leave_zero: assert property (p_overflow_leave_zero) else $error("overflow missed");

    property p_irq_level;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (o_irq && !req.rd && !req.wr) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_flag_only_on_event;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!irq_status_reg[1] && !match_a) |=> !irq_status_reg[1];
    endproperty
    a_flag_only_on_event: assert property (p_flag_only_on_event) else $error("flag set without event");

    property p_disconnected;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !timer_control_a_reg[7] |-> (!o_pwm_out_a && !o_pwm_out_a_oe);
    endproperty
    a_disconnected: assert property (p_disconnected) else $error("pin driven when off");
endmodule

// File: pwm_timer_pkg.sv
// Shared constants and types for the phase-correct PWM timer
package pwm_timer_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFF_CONTROL     = 4'h0;
    localparam logic [3:0] OFF_CLOCK_SEL   = 4'h1;
    localparam logic [3:0] OFF_COUNT_LO    = 4'h2;
    localparam logic [3:0] OFF_COUNT_HI    = 4'h3;
    localparam logic [3:0] OFF_CMP_A_LO    = 4'h4;
    localparam logic [3:0] OFF_CMP_A_HI    = 4'h5;
    localparam logic [3:0] OFF_CMP_B_LO    = 4'h6;
    localparam logic [3:0] OFF_CMP_B_HI    = 4'h7;
    localparam logic [3:0] OFF_IRQ_STATUS  = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK    = 4'h9;

    // Control register fields
    localparam int CTL_MODE_A_HI = 7;
    localparam int CTL_MODE_A_LO = 6;
    localparam int CTL_MODE_B_HI = 5;
    localparam int CTL_MODE_B_LO = 4;
    localparam int CTL_RES_HI    = 1;
    localparam int CTL_RES_LO    = 0;

    // Status and mask bit positions
    localparam int ST_OVERFLOW = 0;
    localparam int ST_MATCH_A  = 1;
    localparam int ST_MATCH_B  = 2;

    // Reset values
    localparam logic [7:0] CONTROL_RST  = 8'h00;
    localparam logic [2:0] CLK_SEL_RST  = 3'h0;
    localparam logic [9:0] CMP_RST      = 10'h000;
    localparam logic [9:0] COUNT_RST    = 10'h000;
    localparam logic [2:0] IRQ_RST      = 3'h0;

    // Clock select codes
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIV1   = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;

    // Peaks per resolution
    localparam logic [9:0] PEAK_8  = 10'h0ff;
    localparam logic [9:0] PEAK_9  = 10'h1ff;
    localparam logic [9:0] PEAK_10 = 10'h3ff;

    localparam int PRESCALE_W = 10;

    // Output modes
    localparam logic [1:0] MODE_NONINV = 2'h2;
    localparam logic [1:0] MODE_INV    = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage
